// [hw/adcrc_top.sv]
/*
 * Converter digital control: channel select, conversion sequencing, result
 * formatting with high/low read interlock, and clock source and prescaler,
 * reached over AXI4-Lite.
 * Assumes an analog core that samples convChannel and delivers a 10-bit code
 * on convData by the end of each conversion, and a synchronous oscillator tick.
 */
//
// What this block does
// - Five-bit channel code selects inputs zero to 23.
// - All-ones channel code powers the converter off.
// - First conversion after power-off is for settling.
// - Codes 29 and 30 select high, low reference.
// - Codes 24 to 28 give undefined results.
// - Left format: top eight high, two low bits.
// - Right format: two MSBs high, eight LSBs low.
// - Signed left format inverts the result MSB.
// - Truncation puts top eight in low byte.
// - Reading high byte freezes low until read.
// - Truncation byte refreshes on every conversion end.
// - Prescaler divides by one, two, four, eight, sixteen.
// - Select bit: one bus clock, zero oscillator.
// - Format field selects placement, resets right-aligned.
// - One conversion per write unless continuous mode.
// - Done flag sets at end, clears on read.
// - Interrupt at end, cleared by read or write.
// - With interrupts enabled done flag reads zero.
`timescale 1ns/1ps
module adcrc_top (
    // Clock and reset.
    input  wire logic        core_clk,
    input  wire logic        nrst,
    // Oscillator tick, one cycle per oscillator period.
    input  wire logic        oscTick,
    // AXI4-Lite write address and data.
    input  wire logic [3:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    // AXI4-Lite write response.
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // AXI4-Lite read.
    input  wire logic [3:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // Analog core.
    output logic [4:0]       convChannel,
    output logic             convPowerDown,
    output logic             convStart,
    output logic             convSettling,
    input  wire logic [9:0]  convData,
    // Conversion interrupt request.
    output logic             convIrq
);
    import adcrc_pkg::*;

    typedef enum logic [2:0] {
        ADCRC_ST_IDLE = 3'b001,
        ADCRC_ST_CONV = 3'b010,
        ADCRC_ST_DONE = 3'b100
    } adcrc_state_t;

    ////////////////////////////////////////////////////////////////////////////
    // Registers and prescaler.

    logic [7:0]   scCtrl_reg;
    logic [7:0]   ckCfg_reg;
    adcrc_state_t state_reg;
    logic [4:0]   cycleCount_reg;
    logic         settle_reg;
    logic         doneFlag_reg;
    logic         irq_reg;
    logic [7:0]   resHigh_reg;
    logic [7:0]   resLow_reg;
    logic         lowFrozen_reg;
    logic         awTaken_reg;
    logic         wTaken_reg;
    logic [3:0]   awAddr_reg;
    logic [7:0]   wByte_reg;
    logic         wLane_reg;

    adcrc_clk_if ck ();

    adcrc_prescaler u_prescaler (
        .core_clk (core_clk),
        .nrst     (nrst),
        .ck       (ck)
    );

    logic [4:0] channel;
    logic       powerOff;
    logic       irqEnable;
    logic       contMode;
    adcrc_fmt_t fmt;
    logic       scWrite;
    logic       hiRead;
    logic       loRead;
    logic       convEnd;

    assign channel   = scCtrl_reg[ADCRC_SC_CHAN_LSB +: ADCRC_CHAN_W];
    assign irqEnable = scCtrl_reg[ADCRC_SC_IRQEN_BIT];
    assign contMode  = scCtrl_reg[ADCRC_SC_CONT_BIT];
    assign fmt       = adcrc_fmt_t'(ckCfg_reg[ADCRC_CK_FMT_LSB +: 2]);
    assign powerOff  = (channel == ADCRC_CHAN_OFF);

    assign ck.oscTick   = oscTick;
    assign ck.selectBus = ckCfg_reg[ADCRC_CK_SRC_BIT];
    assign ck.prescale  = ckCfg_reg[ADCRC_CK_DIV_LSB +: 3];
    assign ck.restart   = scWrite;

    ////////////////////////////////////////////////////////////////////////////
    // AXI4-Lite write path: address and data accepted in either order.

    logic wrFire;
    assign s_axi_awready = !awTaken_reg && !s_axi_bvalid;
    assign s_axi_wready  = !wTaken_reg && !s_axi_bvalid;
    assign wrFire        = awTaken_reg && wTaken_reg && !s_axi_bvalid;
    assign scWrite = wrFire && wLane_reg && (awAddr_reg == ADCRC_OFF_STATUS_CONTROL);
    assign s_axi_bresp = 2'h0;

    // Holding both halves lets the master present them in any order.
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            awTaken_reg <= 1'b0;
            wTaken_reg  <= 1'b0;
            awAddr_reg  <= 4'h0;
            wByte_reg   <= 8'h00;
            wLane_reg   <= 1'b0;
            s_axi_bvalid <= 1'b0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                awTaken_reg <= 1'b1;
                awAddr_reg  <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wTaken_reg <= 1'b1;
                wByte_reg  <= s_axi_wdata[7:0];
                wLane_reg  <= s_axi_wstrb[0];
            end
            if (wrFire) begin
                awTaken_reg  <= 1'b0;
                wTaken_reg   <= 1'b0;
                s_axi_bvalid <= 1'b1;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // Register writes; the done bit position is not writable.
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            scCtrl_reg <= ADCRC_SC_RESET;
            ckCfg_reg  <= ADCRC_CK_RESET;
        end else if (wrFire && wLane_reg) begin
            if (awAddr_reg == ADCRC_OFF_STATUS_CONTROL) begin
                scCtrl_reg <= {1'b0, wByte_reg[6:0]};
            end
            if (awAddr_reg == ADCRC_OFF_CLOCK_CONFIG) begin
                ckCfg_reg <= {wByte_reg[7:2], 2'h0};
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // AXI4-Lite read path, one read at a time.

    logic [7:0] rdByte;
    logic [7:0] hiView;
    // Truncation leaves the high byte unused, even if it still holds an older result.
    assign hiView = (fmt == ADCRC_FMT_TRUNC) ? 8'h00 : resHigh_reg;
    assign s_axi_arready = !s_axi_rvalid;
    assign s_axi_rresp   = 2'h0;
    assign hiRead = s_axi_arvalid && s_axi_arready && (s_axi_araddr == ADCRC_OFF_RESULT_HIGH);
    assign loRead = s_axi_arvalid && s_axi_arready && (s_axi_araddr == ADCRC_OFF_RESULT_LOW);

    // Read mux; unmapped addresses answer zero with OKAY.
    always_comb begin
        unique case (s_axi_araddr)
            ADCRC_OFF_STATUS_CONTROL: rdByte = {doneFlag_reg && !irqEnable, scCtrl_reg[6:0]};
            ADCRC_OFF_RESULT_HIGH:    rdByte = hiView;
            ADCRC_OFF_RESULT_LOW:     rdByte = resLow_reg;
            ADCRC_OFF_CLOCK_CONFIG:   rdByte = ckCfg_reg;
            default:                  rdByte = 8'h00;
        endcase
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= {24'h00_0000, rdByte};
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Conversion sequencer.

    // Each status write starts a fresh conversion, abandoning any running one.
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            state_reg      <= ADCRC_ST_IDLE;
            cycleCount_reg <= 5'h00;
        end else if (scWrite) begin
            state_reg      <= ADCRC_ST_CONV;
            cycleCount_reg <= 5'h00;
        end else begin
            unique case (state_reg)
                ADCRC_ST_IDLE: begin
                    cycleCount_reg <= 5'h00;
                end
                ADCRC_ST_CONV: begin
                    if (powerOff) begin
                        state_reg <= ADCRC_ST_IDLE;
                    end else if (ck.convTick) begin
                        if (cycleCount_reg == 5'(ADCRC_CONV_CYCLES - 1)) begin
                            state_reg <= ADCRC_ST_DONE;
                        end else begin
                            cycleCount_reg <= cycleCount_reg + 5'h01;
                        end
                    end
                end
                ADCRC_ST_DONE: begin
                    cycleCount_reg <= 5'h00;
                    state_reg <= contMode ? ADCRC_ST_CONV : ADCRC_ST_IDLE;
                end
                default: state_reg <= ADCRC_ST_IDLE;
            endcase
        end
    end

    assign convEnd = (state_reg == ADCRC_ST_DONE);
    // Codes 0..23 reach pins, 29/30 the references; 24..28 pass on unchecked.
    assign convChannel   = channel;
    assign convPowerDown = powerOff;
    assign convStart     = (state_reg == ADCRC_ST_CONV) && (cycleCount_reg == 5'h00)
                           && ck.convTick && !powerOff;

    // The first conversion after leaving power-off is flagged as settling.
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            settle_reg <= 1'b1;
        end else if (powerOff) begin
            settle_reg <= 1'b1;
        end else if (convEnd) begin
            settle_reg <= 1'b0;
        end
    end
    // The power-off code itself counts as settling, so the pin rises with the code.
    assign convSettling = settle_reg || powerOff;

    ////////////////////////////////////////////////////////////////////////////
    // Result formatting and interlock.

    logic [7:0] fmtHigh;
    logic [7:0] fmtLow;
    always_comb begin
        unique case (fmt)
            ADCRC_FMT_TRUNC: begin
                fmtHigh = 8'h00;
                fmtLow  = convData[9:2];
            end
            ADCRC_FMT_RIGHT: begin
                fmtHigh = {6'h00, convData[9:8]};
                fmtLow  = convData[7:0];
            end
            ADCRC_FMT_LEFT: begin
                fmtHigh = convData[9:2];
                fmtLow  = {convData[1:0], 6'h00};
            end
            ADCRC_FMT_SIGNED: begin
                fmtHigh = {~convData[9], convData[8:2]};
                fmtLow  = {convData[1:0], 6'h00};
            end
        endcase
    end

    // While frozen, finished results are dropped; truncation never freezes.
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            resHigh_reg   <= 8'h00;
            resLow_reg    <= 8'h00;
            lowFrozen_reg <= 1'b0;
        end else begin
            // A high-byte read in the same cycle also blocks the store, so both
            // bytes that software reads come from one result.
            if (convEnd && (fmt == ADCRC_FMT_TRUNC
                            || (!lowFrozen_reg && !hiRead))) begin
                resHigh_reg <= fmtHigh;
                resLow_reg  <= fmtLow;
            end
            if (loRead || fmt == ADCRC_FMT_TRUNC) begin
                lowFrozen_reg <= 1'b0;
            end else if (hiRead) begin
                lowFrozen_reg <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Done flag and interrupt request; a new end wins over a same-cycle clear.

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            doneFlag_reg <= 1'b0;
            irq_reg      <= 1'b0;
        end else begin
            if (convEnd && !irqEnable) begin
                doneFlag_reg <= 1'b1;
            end else if (hiRead || loRead || irqEnable) begin
                doneFlag_reg <= 1'b0;
            end
            if (convEnd && irqEnable) begin
                irq_reg <= 1'b1;
            end else if (hiRead || loRead || scWrite || !irqEnable) begin
                irq_reg <= 1'b0;
            end
        end
    end
    assign convIrq = irq_reg;

endmodule

// [common/adcrc_pkg.sv]
/*
 * Constants for the converter control block: register offsets, field positions,
 * reset values, channel codes, result formats and converter timing.
 * Assumes nothing of its surroundings beyond a SystemVerilog compiler.
 */
package adcrc_pkg;

    // Register byte offsets on the AXI4-Lite bus.
    localparam logic [3:0] ADCRC_OFF_STATUS_CONTROL = 4'h0;
    localparam logic [3:0] ADCRC_OFF_RESULT_HIGH    = 4'h4;
    localparam logic [3:0] ADCRC_OFF_RESULT_LOW     = 4'h8;
    localparam logic [3:0] ADCRC_OFF_CLOCK_CONFIG   = 4'hc;

    // Status and control register fields.
    localparam int ADCRC_SC_DONE_BIT = 7;
    localparam int ADCRC_SC_IRQEN_BIT = 6;
    localparam int ADCRC_SC_CONT_BIT = 5;
    localparam int ADCRC_SC_CHAN_LSB = 0;
    localparam int ADCRC_CHAN_W      = 5;

    // Clock configuration register fields.
    localparam int ADCRC_CK_DIV_LSB  = 5;
    localparam int ADCRC_CK_SRC_BIT  = 4;
    localparam int ADCRC_CK_FMT_LSB  = 2;

    // Reset values: converter powered off, oscillator source, right-aligned.
    localparam logic [7:0] ADCRC_SC_RESET = 8'h1f;
    localparam logic [7:0] ADCRC_CK_RESET = 8'h04;

    // Channel codes of note.
    localparam logic [4:0] ADCRC_CHAN_LAST_EXT = 5'h17;
    localparam logic [4:0] ADCRC_CHAN_REF_HIGH = 5'h1d;
    localparam logic [4:0] ADCRC_CHAN_REF_LOW  = 5'h1e;
    localparam logic [4:0] ADCRC_CHAN_OFF      = 5'h1f;

    // Result placement formats.
    typedef enum logic [1:0] {
        ADCRC_FMT_TRUNC  = 2'h0,
        ADCRC_FMT_RIGHT  = 2'h1,
        ADCRC_FMT_LEFT   = 2'h2,
        ADCRC_FMT_SIGNED = 2'h3
    } adcrc_fmt_t;

    // One conversion lasts this many converter clock periods.
    localparam int ADCRC_CONV_CYCLES = 17;
    localparam int ADCRC_RESULT_W    = 10;

endpackage

// [common/adcrc_clk_if.sv]
/*
 * Interface between the control block and its converter clock prescaler.
 * Assumes one system clock shared by both ends.
 */
`timescale 1ns/1ps
interface adcrc_clk_if;
    logic       oscTick;
    logic       selectBus;
    logic [2:0] prescale;
    logic       restart;
    logic       convTick;

    modport ctrl (output selectBus, output prescale, output restart, output oscTick,
                  input convTick);
    modport div (input selectBus, input prescale, input restart, input oscTick,
                 output convTick);
endinterface

// [hw/adcrc_prescaler.sv]
/*
 * Converter clock prescaler: picks the bus clock or oscillator tick as input
 * and divides it by 1, 2, 4, 8 or 16 into a one-cycle enable pulse.
 * Assumes the oscillator tick is a one-cycle pulse synchronous to core_clk.
 */
`timescale 1ns/1ps
module adcrc_prescaler (
    // Clock and reset.
    input wire logic    core_clk,
    input wire logic    nrst,
    // Control side.
    adcrc_clk_if.div    ck
);
    import adcrc_pkg::*;

    logic [3:0] divCount_reg;
    logic       srcTick;
    logic [3:0] divMask;

    // Bus clock runs every cycle; the oscillator only on its tick.
    assign srcTick = ck.selectBus ? 1'b1 : ck.oscTick;

    // Any ratio with the top bit set divides by sixteen.
    always_comb begin
        unique case (ck.prescale)
            3'h0:    divMask = 4'h0;
            3'h1:    divMask = 4'h1;
            3'h2:    divMask = 4'h3;
            3'h3:    divMask = 4'h7;
            default: divMask = 4'hf;
        endcase
    end

    // Free counter; restart realigns it so a new conversion starts cleanly.
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            divCount_reg <= 4'h0;
        end else if (ck.restart) begin
            divCount_reg <= 4'h0;
        end else if (srcTick) begin
            divCount_reg <= divCount_reg + 4'h1;
        end
    end

    assign ck.convTick = srcTick && ((divCount_reg & divMask) == divMask);
endmodule

// [bench/adcrc_asserts.sv]
/*
 * Port-level checks of the converter control block.
 * Assumes it is bound to adcrc_top and sees its ports by name.
 */
`timescale 1ns/1ps
module adcrc_asserts (
    // Clock and reset.
    input wire logic        core_clk,
    input wire logic        nrst,
    // Bus side.
    input wire logic [3:0]  s_axi_awaddr,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0]  s_axi_wstrb,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic        s_axi_bvalid,
    input wire logic [3:0]  s_axi_araddr,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic        s_axi_rvalid,
    // Analog core side.
    input wire logic [4:0]  convChannel,
    input wire logic        convPowerDown,
    input wire logic        convStart,
    input wire logic        convSettling,
    input wire logic        convIrq
);
    logic [3:0] lastAw, lastAr;
    logic [7:0] lastW;
    logic       lastStrb, ckSeen;
    logic [1:0] fmtSeen;

    ////////////////////////////////////////
    // Address and data arrive on separate channels, so remember each one.
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            {lastAw, lastAr, lastW, lastStrb, ckSeen} <= 18'h0;
            fmtSeen <= 2'h1;
        end else begin
            if (s_axi_awvalid && s_axi_awready) lastAw <= s_axi_awaddr;
            if (s_axi_wvalid && s_axi_wready) lastW <= s_axi_wdata[7:0];
            if (s_axi_wvalid && s_axi_wready) lastStrb <= s_axi_wstrb[0];
            if (s_axi_arvalid && s_axi_arready) lastAr <= s_axi_araddr;
            if ($rose(s_axi_bvalid) && lastAw == 4'hc && lastStrb) ckSeen <= 1'b1;
            if ($rose(s_axi_bvalid) && lastAw == 4'hc && lastStrb) fmtSeen <= lastW[3:2];
        end
    end

    ////////////////////////////////////////
    default clocking dc @(posedge core_clk); endclocking
    default disable iff (!nrst);

    property p_off_code;
        convPowerDown == (convChannel == 5'h1f);
    endproperty
    a_off_code: assert property (p_off_code)
        else $error("power down does not match channel code");
    property p_off_idle;
        convPowerDown |-> !convStart;
    endproperty
    a_off_idle: assert property (p_off_idle)
        else $error("conversion started while powered off");
    property p_off_settle;
        convPowerDown |-> convSettling;
    endproperty
    a_off_settle: assert property (p_off_settle)
        else $error("settling flag low while powered off");
    property p_chan_write;
        $changed(convChannel) |-> $rose(s_axi_bvalid) && lastAw == 4'h0;
    endproperty
    a_chan_write: assert property (p_chan_write)
        else $error("channel changed without a control write");
    property p_ctl_start;
        $rose(s_axi_bvalid) && lastAw == 4'h0 && lastStrb && !convPowerDown
            |-> ##[0:300] convStart;
    endproperty
    a_ctl_start: assert property (p_ctl_start)
        else $error("control write started no conversion");
    property p_ctl_irq;
        $rose(s_axi_bvalid) && lastAw == 4'h0 && lastStrb |-> ##[0:1] !convIrq;
    endproperty
    a_ctl_irq: assert property (p_ctl_irq)
        else $error("interrupt kept after control write");
    property p_irq_done;
        s_axi_rvalid && lastAr == 4'h0 |-> !(s_axi_rdata[7] && s_axi_rdata[6]);
    endproperty
    a_irq_done: assert property (p_irq_done)
        else $error("done flag set with interrupt enabled");
    property p_ck_reset;
        s_axi_rvalid && lastAr == 4'hc && !ckSeen |-> s_axi_rdata[7:0] == 8'h04;
    endproperty
    a_ck_reset: assert property (p_ck_reset)
        else $error("clock config reset value wrong");
    property p_trunc_hi;
        s_axi_rvalid && lastAr == 4'h4 && fmtSeen == 2'h0 |-> s_axi_rdata == 32'h0;
    endproperty
    a_trunc_hi: assert property (p_trunc_hi)
        else $error("high byte not zero in truncation");

    c_start: cover property (convStart);
    c_irq: cover property ($rose(convIrq));
    c_hi_read: cover property (s_axi_rvalid && lastAr == 4'h4);
endmodule

// [bench/adcrc_core_model.sv]
/*
 * Behavioural analog core: takes the code offered by the bench at each
 * conversion start, mixed with the channel, and holds it until the next unless powered off.
 * Assumes convStart is a one-cycle pulse in the core_clk domain.
 */
`timescale 1ns/1ps
module adcrc_core_model (
    // Clock and reset.
    input wire logic       core_clk,
    input wire logic       nrst,
    // Control from the block.
    input wire logic       convStart,
    input wire logic       convPowerDown,
    input wire logic [4:0] convChannel,
    // Next code to convert.
    input wire logic [9:0] nextData,
    // Result.
    output logic     [9:0] convData
);
    // A powered-off core toggles its output so a stale code never looks valid.
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            convData <= 10'h0;
        end else if (convStart) begin
            convData <= nextData ^ {5'h0, convChannel};
        end else if (convPowerDown) begin
            convData <= ~convData;
        end
    end
endmodule

// [bench/adcrc_top_tb.sv]
/*
 * Bench for the converter control block: bus tasks, a read queue checked
 * by a monitor, channel, format, interlock, interrupt and prescaler runs.
 * Assumes package, design, core model and checker are compiled first.
 */
`timescale 1ns/1ps
module adcrc_top_tb;
    import adcrc_pkg::*;

    logic        core_clk, nrst, oscTick, convStart, convPowerDown;
    logic        convSettling, convIrq, s_axi_awvalid, s_axi_awready;
    logic        s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [1:0]  s_axi_bresp, s_axi_rresp, oscCnt;
    logic [3:0]  s_axi_awaddr, s_axi_wstrb, s_axi_araddr;
    logic [4:0]  convChannel;
    logic [9:0]  convData, nextData;
    logic [31:0] s_axi_wdata, s_axi_rdata, expQ[$];
    logic [7:0]  ckTab[7] = '{8'h14, 8'h34, 8'h54, 8'h74, 8'h94, 8'hf4, 8'h04};
    int          gapTab[7] = '{18, 34, 68, 136, 272, 272, 68};
    int          failCount, numChecks, seed;

    adcrc_top        adcrc_top_i (.*);
    adcrc_core_model adcrc_core_model_i (.*);

    ////////////////////////////////////////
    // Clock; the oscillator tick comes every fourth cycle.
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    always @(posedge core_clk) begin
        oscCnt  <= nrst ? oscCnt + 2'h1 : 2'h0;
        oscTick <= nrst && (oscCnt == 2'h3);
    end

    task automatic chkVal(input string nm, input logic [31:0] e, input logic [31:0] g);
        numChecks++;
        if (g !== e) begin
            failCount++;
            $display("BAD %s exp %h got %h", nm, e, g);
        end
    endtask

    // Each read answer is matched to the oldest noted expectation.
    always @(posedge core_clk) begin
        if (s_axi_rvalid === 1'b1 && expQ.size() > 0) begin
            chkVal("rdata", expQ[0], s_axi_rdata);
            chkVal("rresp", 2'h0, s_axi_rresp);
            expQ.delete(0);
        end
    end

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        logic aw, w;
        {aw, w} = 2'h0;
        s_axi_awaddr  <= a;
        s_axi_wdata   <= {24'h0, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        while (!(aw && w)) begin
            @(posedge core_clk);
            if (s_axi_awvalid && s_axi_awready) aw = 1'b1;
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) w = 1'b1;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
        end
        do @(posedge core_clk); while (s_axi_bvalid !== 1'b1);
        chkVal("bresp", 2'h0, s_axi_bresp);
    endtask

    task automatic rd(input logic [3:0] a, input logic [31:0] e);
        expQ.push_back(e);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        do @(posedge core_clk); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        do @(posedge core_clk); while (s_axi_rvalid !== 1'b1);
    endtask

    task automatic waitStart();
        int k;
        k = 0;
        while (convStart !== 1'b1 && k < 400) begin
            @(posedge core_clk);
            k++;
        end
    endtask

    // Single conversion; d returns the code the core will deliver.
    task automatic conv(input logic [7:0] ctl, output logic [9:0] d);
        int k;
        d = 10'($random(seed));
        nextData <= d;
        d = d ^ {5'h0, ctl[4:0]};
        wr(4'h0, ctl);
        waitStart();
        k = 0;
        repeat (40) begin
            @(posedge core_clk);
            if (convStart === 1'b1) k++;
        end
        chkVal("extra starts", 0, k);
    endtask

    function automatic logic [15:0] place(input logic [1:0] f, input logic [9:0] d);
        case (f)
            2'h0: return {8'h0, d[9:2]};
            2'h1: return {6'h0, d};
            2'h2: return {d[9:2], d[1:0], 6'h0};
            default: return {~d[9], d[8:2], d[1:0], 6'h0};
        endcase
    endfunction

    task automatic printVerdict();
        $display("checks %0d mismatches %0d", numChecks, failCount);
        if (failCount == 0 && numChecks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge core_clk);
        failCount++;
        printVerdict();
    end

    ////////////////////////////////////////
    initial begin
        logic [9:0]  d, d2;
        logic [15:0] p, p2;
        logic [4:0]  ch;
        int          t;
        {seed, nrst, nextData} = {32'd19344, 11'h0};
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = {40'h0, 4'h1};
        {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = 3'h0;
        {s_axi_bready, s_axi_rready} = 2'h3;
        repeat (5) @(posedge core_clk);
        nrst <= 1'b1;
        rd(4'h0, 32'h1f);
        rd(4'hc, 32'h04);
        for (int c = 0; c < 31; c++) begin
            wr(4'h0, 8'(c));
            chkVal("channel", c, convChannel);
        end
        waitStart();
        wr(4'h0, 8'h1f);
        chkVal("power down", 1, convPowerDown);
        for (int f = 0; f < 4; f++) begin
            wr(4'hc, {4'h1, 2'(f), 2'h0});
            ch = 5'($unsigned($random(seed)) % 24);
            chkVal("settling", f == 0, convSettling);
            conv({3'h0, ch}, d);
            chkVal("settling", 0, convSettling);
            p = place(2'(f), d);
            rd(4'h0, {24'h0, 3'h4, ch});
            rd(4'h4, {24'h0, p[15:8]});
            rd(4'h8, {24'h0, p[7:0]});
            rd(4'h0, {24'h0, 3'h0, ch});
        end
        // A second result arrives between the high and low reads.
        for (int f = 1; f >= 0; f--) begin
            wr(4'hc, {4'h1, 2'(f), 2'h0});
            conv(8'h03, d);
            p = place(2'(f), d);
            rd(4'h4, {24'h0, p[15:8]});
            conv(8'h04, d2);
            p2 = place(2'(f), d2);
            rd(4'h8, {24'h0, (f != 0) ? p[7:0] : p2[7:0]});
        end
        wr(4'hc, 8'h14);
        conv(8'h45, d);
        chkVal("irq", 1, convIrq);
        rd(4'h0, 32'h45);
        rd(4'h4, {30'h0, d[9:8]});
        chkVal("irq", 0, convIrq);
        rd(4'h8, {24'h0, d[7:0]});
        conv(8'h45, d);
        wr(4'h0, 8'h5f);
        chkVal("irq", 0, convIrq);
        foreach (ckTab[i]) begin
            wr(4'hc, ckTab[i]);
            wr(4'h0, 8'h25);
            waitStart();
            t = 0;
            do begin
                @(posedge core_clk);
                t++;
            end while (convStart !== 1'b1 && t < 600);
            chkVal("start gap", gapTab[i], t);
            wr(4'h0, 8'h1f);
        end
        printVerdict();
    end
endmodule

bind adcrc_top adcrc_asserts adcrc_asserts_i (.*);
